// ### pkg/dbcm_pkg.sv
// Purpose: Constants and types for the bus comparator match block
// Assumes: 32-bit Avalon-MM register port, byte addresses
// Notes:   All offsets, field positions and config register reset values live here
package dbcm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [9:0] OFF_DEBUG_CTRL = 10'h100;
    localparam logic [9:0] OFF_A_DVAL    = 10'h118;
    localparam logic [9:0] OFF_A_DMASK   = 10'h11C;
    localparam logic [9:0] OFF_B_CTRL    = 10'h120;
    localparam logic [9:0] OFF_B_ADDR    = 10'h124;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of the comparator control bytes
    localparam int CTL_ON_BIT   = 0;
    localparam int CTL_DIRQ_BIT = 2;
    localparam int CTL_RW_BIT   = 3;
    localparam int CTL_OPC_BIT  = 5;
    localparam logic [7:0] CTL_WMASK = 8'h2D;  // Writable bits 5,3,2,0

    // Field positions of the debug control register
    localparam int ARM_BIT      = 0;
    localparam int RANGE_LSB    = 1;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] RST_DVAL  = 32'h0000_0000;
    localparam logic [31:0] RST_DMASK = 32'h0000_0000;
    localparam logic [7:0]  RST_BCTL  = 8'h00;
    localparam logic [23:0] RST_BADDR = 24'h00_0000;
    localparam logic [1:0]  RST_RANGE = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Whole block state, registered as one word
    typedef struct packed {
        logic [31:0] dval;       // cmp_a_data_value
        logic [31:0] dmask;      // cmp_a_data_mask
        logic [7:0]  bctl;       // cmp_b_control
        logic [23:0] baddr;      // cmp_b_address
        logic        armed;
        logic [1:0]  range;      // ab_range_config
        logic        wreq;       // Avalon waitrequest
        logic [31:0] rdata;
        logic [1:0]  match;
        logic        range_hit;
    } dbcm_state_t;

    // Observed processor bus, bundled
    typedef struct packed {
        logic        valid;
        logic        read;
        logic [23:0] addr;
        logic [31:0] data;
        logic        opc_exec;
        logic [23:0] opc_addr;
    } dbcm_bus_t;

endpackage

// ### hw/dbcm_top.sv
// Purpose: Breakpoint comparators A (data) and B (address) with regs
// Assumes: Observed bus and sequencer run on SYS_CLK, no synchroniser
// Notes:   Match outputs are one-cycle pulses, one cycle after the bus
//
// How it works
// - Data value, 32 bits, byte 0 is MSB
// - Data mask, 32 bits, byte 0 is MSB
// - Reads always; writes except the arm bit ignored while armed
// - Stored data bit must equal bus bit
// - Mask zero bit always matches
// - Mask rule applies to every data bit
// - B control bits 5,3,2,0; rest zero
// - Opcode select picks PC or data address
// - Direction bit: 0 write, 1 read
// - Direction value ignored if unqualified or opcode
// - Direction enable ignored in opcode mode
// - Opcode match ignores data and direction
// - B matches only while enabled
// - Range mode uses A control, not B
// - B holds 24-bit exact address
// - Arm bit arms; final state disarms
// - A,B drive match 0,1 outside range
// - Opcode match at execution stage entry
`timescale 1ns/1ns
module dbcm_top #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 32
) (
    // Clock and reset
    input  wire logic                   SYS_CLK,
    input  wire logic                   RESET,
    // Avalon-MM slave
    input  wire logic [9:0]             AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    output logic      [31:0]            AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    // Observed processor bus and neighbours
    input  wire dbcm_pkg::dbcm_bus_t    CPU_BUS,
    input  wire logic [7:0]             CMP_A_CONTROL,
    input  wire logic                   SEQ_FINAL,
    // Results
    output logic [1:0]                  MATCH,
    output logic                        RANGE_B_HIT,
    output logic                        ARMED
);

    ////////////////////////////////////////////////////////////////////////
    // Widths are fixed by the register layout
    if (ADDR_W != 24 || DATA_W != 32) begin : g_bad_width
        $error("dbcm_top supports only ADDR_W=24 and DATA_W=32");
    end

    dbcm_pkg::dbcm_state_t s_r;
    dbcm_pkg::dbcm_state_t s_nxt;

    logic        acc;        // Access completes this cycle
    logic        wr_ok;      // Config write allowed
    logic [7:0]  ctl;        // Control byte in force
    logic        rng;
    logic        dir_ok;
    logic        a_hit;
    logic        b_hit;
    logic [31:0] a_diff;

    ////////////////////////////////////////////////////////////////////////
    // Byte lane k of a word register maps to bits 31-8k down
    function automatic logic [31:0] swap(input logic [31:0] v);
        swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: bus slave, arming and comparators
    always_comb begin
        s_nxt  = s_r;
        acc    = (AVS_READ | AVS_WRITE) & ~s_r.wreq;
        wr_ok  = AVS_WRITE & acc & ~s_r.armed;
        rng    = (s_r.range != 2'h0);
        // Range mode hands B's qualifiers over to A's control byte
        ctl    = rng ? CMP_A_CONTROL : s_r.bctl;
        // Direction check only when qualified; rw bit else unused
        dir_ok = ~ctl[dbcm_pkg::CTL_DIRQ_BIT]
               | (CPU_BUS.read == ctl[dbcm_pkg::CTL_RW_BIT]);
        // Opcode path ignores data and direction entirely
        if (ctl[dbcm_pkg::CTL_OPC_BIT]) begin
            b_hit = CPU_BUS.opc_exec
                  & (CPU_BUS.opc_addr == s_r.baddr);
        end else begin
            b_hit = CPU_BUS.valid & dir_ok
                  & (CPU_BUS.addr == s_r.baddr);
        end
        b_hit  = b_hit & ctl[dbcm_pkg::CTL_ON_BIT];
        // Masked data compare; zero mask bits never fail
        a_diff = (CPU_BUS.data ^ s_r.dval) & s_r.dmask;
        a_hit  = CMP_A_CONTROL[dbcm_pkg::CTL_ON_BIT]
               & ~CMP_A_CONTROL[dbcm_pkg::CTL_OPC_BIT]
               & CPU_BUS.valid & (a_diff == 32'h0000_0000);
        s_nxt.match     = rng ? 2'b00 : {b_hit, a_hit};
        s_nxt.range_hit = rng & b_hit;

        // One wait state, then a single-cycle acknowledge
        s_nxt.wreq  = ~((AVS_READ | AVS_WRITE) & s_r.wreq);
        s_nxt.rdata = 32'h0000_0000;
        if (AVS_ADDRESS == dbcm_pkg::OFF_DEBUG_CTRL) begin
            s_nxt.rdata[dbcm_pkg::ARM_BIT] = s_r.armed;
            s_nxt.rdata[dbcm_pkg::RANGE_LSB +: 2] = s_r.range;
        end else if (AVS_ADDRESS == dbcm_pkg::OFF_A_DVAL) begin
            s_nxt.rdata = swap(s_r.dval);
        end else if (AVS_ADDRESS == dbcm_pkg::OFF_A_DMASK) begin
            s_nxt.rdata = swap(s_r.dmask);
        end else if (AVS_ADDRESS == dbcm_pkg::OFF_B_CTRL) begin
            s_nxt.rdata[7:0] = s_r.bctl;
        end else if (AVS_ADDRESS == dbcm_pkg::OFF_B_ADDR) begin
            s_nxt.rdata[23:0] = s_r.baddr;
        end

        // Writes, byte by byte
        for (int k = 0; k < 4; k++) begin
            if (wr_ok && AVS_BYTEENABLE[k]) begin
                if (AVS_ADDRESS == dbcm_pkg::OFF_A_DVAL) begin
                    s_nxt.dval[31-8*k -: 8] = AVS_WRITEDATA[8*k +: 8];
                end else if (AVS_ADDRESS == dbcm_pkg::OFF_A_DMASK) begin
                    s_nxt.dmask[31-8*k -: 8] = AVS_WRITEDATA[8*k +: 8];
                end else if (AVS_ADDRESS == dbcm_pkg::OFF_B_ADDR
                             && k < 3) begin
                    s_nxt.baddr[8*k +: 8] = AVS_WRITEDATA[8*k +: 8];
                end
            end
        end
        if (wr_ok && AVS_BYTEENABLE[0]
            && AVS_ADDRESS == dbcm_pkg::OFF_B_CTRL) begin
            s_nxt.bctl = AVS_WRITEDATA[7:0] & dbcm_pkg::CTL_WMASK;
        end
        if (wr_ok && AVS_BYTEENABLE[0]
            && AVS_ADDRESS == dbcm_pkg::OFF_DEBUG_CTRL) begin
            s_nxt.range = AVS_WRITEDATA[dbcm_pkg::RANGE_LSB +: 2];
        end

        // Arm bit stays writable while armed so software can stop
        if (AVS_WRITE && acc && AVS_BYTEENABLE[0]
            && AVS_ADDRESS == dbcm_pkg::OFF_DEBUG_CTRL) begin
            s_nxt.armed = AVS_WRITEDATA[dbcm_pkg::ARM_BIT];
        end
        // Final state wins over a simultaneous arm
        if (SEQ_FINAL) begin
            s_nxt.armed = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            s_r           <= '0;
            s_r.dval      <= dbcm_pkg::RST_DVAL;
            s_r.dmask     <= dbcm_pkg::RST_DMASK;
            s_r.bctl      <= dbcm_pkg::RST_BCTL;
            s_r.baddr     <= dbcm_pkg::RST_BADDR;
            s_r.range     <= dbcm_pkg::RST_RANGE;
            s_r.wreq      <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign AVS_READDATA    = s_r.rdata;
    assign AVS_WAITREQUEST = s_r.wreq;
    assign MATCH           = s_r.match;
    assign RANGE_B_HIT     = s_r.range_hit;
    assign ARMED           = s_r.armed;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Armed write to data value leaves it unchanged
    property p_armed_hold;
        @(posedge SYS_CLK) disable iff (RESET)
        (s_r.armed && AVS_WRITE && !s_r.wreq && !SEQ_FINAL)
            |=> $stable(s_r.dval) && $stable(s_r.dmask)
                && $stable(s_r.bctl) && $stable(s_r.baddr);
    endproperty
    a_armed_hold: assert property (p_armed_hold)
        else $error("config changed while armed");

    // Lane 0 write lands in bits 31:24 of the data value
    property p_lane0;
        @(posedge SYS_CLK) disable iff (RESET)
        (!s_r.armed && AVS_WRITE && !s_r.wreq && AVS_BYTEENABLE == 4'h1
         && AVS_ADDRESS == dbcm_pkg::OFF_A_DVAL)
            |=> s_r.dval[31:24] == $past(AVS_WRITEDATA[7:0])
                && s_r.dval[23:0] == $past(s_r.dval[23:0]);
    endproperty
    a_lane0: assert property (p_lane0)
        else $error("data lane 0 not in top byte");

    // Mask lane 3 lands in bits 7:0
    property p_mask_lane3;
        @(posedge SYS_CLK) disable iff (RESET)
        (!s_r.armed && AVS_WRITE && !s_r.wreq && AVS_BYTEENABLE == 4'h8
         && AVS_ADDRESS == dbcm_pkg::OFF_A_DMASK)
            |=> s_r.dmask[7:0] == $past(AVS_WRITEDATA[31:24]);
    endproperty
    a_mask_lane3: assert property (p_mask_lane3)
        else $error("mask lane 3 not in low byte");

    // Unimplemented control bits never read back
    property p_bctl_zero;
        @(posedge SYS_CLK) disable iff (RESET)
        (s_r.bctl & ~dbcm_pkg::CTL_WMASK) == 8'h00;
    endproperty
    a_bctl_zero: assert property (p_bctl_zero)
        else $error("reserved control bits set");

    // Match A exactly when masked data agrees
    property p_match_a;
        @(posedge SYS_CLK) disable iff (RESET)
        (!rng && CPU_BUS.valid && CMP_A_CONTROL[0] && !CMP_A_CONTROL[5])
            |=> MATCH[0] == ((($past(CPU_BUS.data) ^ $past(s_r.dval))
                              & $past(s_r.dmask)) == 32'h0000_0000);
    endproperty
    a_match_a: assert property (p_match_a)
        else $error("comparator A data match wrong");

    // Disabled B, or range mode, never raises match 1
    property p_b_off;
        @(posedge SYS_CLK) disable iff (RESET)
        (!ctl[0] || rng) |=> !MATCH[1];
    endproperty
    a_b_off: assert property (p_b_off)
        else $error("match 1 while B inactive");

    // Qualified data match obeys the direction bit
    property p_dir;
        @(posedge SYS_CLK) disable iff (RESET)
        (!rng && s_r.bctl == 8'h05 && CPU_BUS.read) |=> !MATCH[1];
    endproperty
    a_dir: assert property (p_dir)
        else $error("write-only comparator hit a read");

    // Opcode mode hits on execution entry regardless of direction
    property p_opc;
        @(posedge SYS_CLK) disable iff (RESET)
        (!rng && ctl[0] && ctl[5] && CPU_BUS.opc_exec
         && CPU_BUS.opc_addr == s_r.baddr) |=> MATCH[1];
    endproperty
    a_opc: assert property (p_opc)
        else $error("opcode address match missed");

    // Final state drops the armed flag on the next edge
    property p_disarm;
        @(posedge SYS_CLK) disable iff (RESET)
        SEQ_FINAL |=> !ARMED;
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("not disarmed after final state");

    // Every request is answered after exactly one wait cycle
    property p_wait;
        @(posedge SYS_CLK) disable iff (RESET)
        ((AVS_READ || AVS_WRITE) && s_r.wreq) |=> !AVS_WAITREQUEST
            ##1 AVS_WAITREQUEST;
    endproperty
    a_wait: assert property (p_wait)
        else $error("bus answer timing wrong");

    // Range mode keeps both direct match lines low
    property p_range_quiet;
        @(posedge SYS_CLK) disable iff (RESET)
        rng |=> MATCH == 2'b00;
    endproperty
    a_range_quiet: assert property (p_range_quiet)
        else $error("direct match raised in range mode");

    // Unqualified data match hits on either direction
    property p_rw_ignored;
        @(posedge SYS_CLK) disable iff (RESET)
        (!rng && s_r.bctl[0] && !s_r.bctl[5] && !s_r.bctl[2]
         && CPU_BUS.valid && CPU_BUS.addr == s_r.baddr) |=> MATCH[1];
    endproperty
    a_rw_ignored: assert property (p_rw_ignored)
        else $error("unqualified address match missed");

    // In range mode B is qualified by A's control byte
    property p_range_b;
        @(posedge SYS_CLK) disable iff (RESET)
        (rng && CMP_A_CONTROL[0] && !CMP_A_CONTROL[5] && CPU_BUS.valid
         && CPU_BUS.addr == s_r.baddr
         && (!CMP_A_CONTROL[2] || CPU_BUS.read == CMP_A_CONTROL[3]))
            |=> RANGE_B_HIT;
    endproperty
    a_range_b: assert property (p_range_b)
        else $error("range mode B hit missed");

    // A data access elsewhere never hits comparator B
    property p_addr_miss;
        @(posedge SYS_CLK) disable iff (RESET)
        (!rng && !s_r.bctl[5] && CPU_BUS.addr != s_r.baddr) |=> !MATCH[1];
    endproperty
    a_addr_miss: assert property (p_addr_miss)
        else $error("match 1 on a foreign address");

endmodule

// ### tb/dbcm_cpu_model.sv
// Purpose: Processor bus model facing the comparators
// Assumes: Bench hands over one bus cycle per clock through go/req
// Notes:   An idle bus shows junk that flips each cycle, old values every second cycle
`timescale 1ns/1ns
module dbcm_cpu_model (
    // Clock
    input  wire logic                clk,
    // Cycle requested by the bench
    input  wire logic                go,
    input  wire dbcm_pkg::dbcm_bus_t req,
    // Bus seen by the block
    output dbcm_pkg::dbcm_bus_t      bus
);
    logic [81:0] junk_r = '0;

    ////////////////////////////////////////////////////////////////////
    // Junk flips so a stale cycle can never pass for a live one
    always @(posedge clk) junk_r <= go ? ~req : ~junk_r;

    // Strobes drop whenever no cycle runs
    always_comb begin
        bus = go ? req : dbcm_pkg::dbcm_bus_t'(junk_r);
        if (!go) begin
            bus.valid    = 1'h0;
            bus.opc_exec = 1'h0;
        end
    end
endmodule

// ### tb/debug_bus_comparator_match_tb.sv
// Purpose: Self-checking bench for the bus comparator block
// Assumes: One wait cycle per register access, match one cycle late
// Notes:   Shadow registers predict reads and match pulses
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
$display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module debug_bus_comparator_match_tb;
    logic                SYS_CLK = 1'h0;
    logic                RESET = 1'h1;
    logic [9:0]          AVS_ADDRESS = '0;
    logic                AVS_READ = 1'h0;
    logic                AVS_WRITE = 1'h0;
    logic [3:0]          AVS_BYTEENABLE = '0;
    logic [31:0]         AVS_WRITEDATA = '0;
    logic [31:0]         AVS_READDATA;
    logic                AVS_WAITREQUEST;
    logic [7:0]          CMP_A_CONTROL = '0;
    logic                SEQ_FINAL = 1'h0;
    logic [1:0]          MATCH;
    logic                RANGE_B_HIT;
    logic                ARMED;
    logic                go = 1'h0;
    dbcm_pkg::dbcm_bus_t req = '0;
    dbcm_pkg::dbcm_bus_t CPU_BUS;
    // Shadow of what the block should hold
    logic [31:0]         rd, dv = '0, dm = '0, seed = 32'h4F;
    logic [7:0]          bc = '0;
    logic [23:0]         ba = '0;
    logic                rng = 1'h0, arm = 1'h0;
    int                  failures = 0, n_checks = 0;

    always #2 SYS_CLK = ~SYS_CLK;

    dbcm_top i_dut (.SYS_CLK(SYS_CLK), .RESET(RESET),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .CPU_BUS(CPU_BUS),
        .CMP_A_CONTROL(CMP_A_CONTROL), .SEQ_FINAL(SEQ_FINAL),
        .MATCH(MATCH), .RANGE_B_HIT(RANGE_B_HIT), .ARMED(ARMED));
    dbcm_cpu_model i_cpu (.clk(SYS_CLK), .go(go), .req(req), .bus(CPU_BUS));

    ////////////////////////////////////////////////////////////////////
    // Prediction helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Lane 0 carries the top byte, so words travel byte-swapped
    function automatic logic [31:0] sw(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    function automatic logic eb(input logic [7:0] c,
                                input dbcm_pkg::dbcm_bus_t b);
        if (!c[0]) return 1'h0;
        if (c[5]) return b.opc_exec && b.opc_addr == ba;
        return b.valid && b.addr == ba && (!c[2] || b.read == c[3]);
    endfunction
    function automatic logic ea(input logic [7:0] c,
                                input dbcm_pkg::dbcm_bus_t b);
        return c[0] && !c[5] && b.valid && ((b.data ^ dv) & dm) == '0;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Register bus master; only the watchdog bounds the wait
    task automatic av(input logic w, input logic [9:0] a,
                      input logic [3:0] be, input logic [31:0] d);
        @(posedge SYS_CLK);
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_ADDRESS <= a;
        AVS_BYTEENABLE <= be;
        AVS_WRITEDATA <= d;
        // Request stands until the edge that sees waitrequest low
        do begin
            @(posedge SYS_CLK);
        end while (AVS_WAITREQUEST);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'h0;
        AVS_READ <= 1'h0;
    endtask
    task automatic chk(input logic [9:0] a, input logic [31:0] e);
        av(1'h0, a, 4'hF, '0);
        `CHK(rd, e)
    endtask
    // Shadows follow only while disarmed
    task automatic cfg(input logic [31:0] v, m, input logic [7:0] c,
                       input logic [23:0] a);
        av(1'h1, 10'h118, 4'hF, sw(v));
        av(1'h1, 10'h11C, 4'hF, sw(m));
        av(1'h1, 10'h120, 4'h1, {24'h0, c});
        av(1'h1, 10'h124, 4'h7, {8'h0, a});
        if (!arm) begin
            dv = v;
            dm = m;
            bc = c & 8'h2D;
            ba = a;
        end
    endtask
    // One bus cycle, result one clock later
    task automatic cyc(input dbcm_pkg::dbcm_bus_t b, input logic [7:0] ac);
        @(posedge SYS_CLK);
        go <= 1'h1;
        req <= b;
        CMP_A_CONTROL <= ac;
        @(posedge SYS_CLK);
        go <= 1'h0;
        #1;
        if (rng) begin
            `CHK(MATCH, 2'h0)
            `CHK(RANGE_B_HIT, eb(ac, b))
        end else begin
            `CHK(MATCH, {eb(bc, b), ea(ac, b)})
            `CHK(RANGE_B_HIT, 1'h0)
        end
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Watchdog, about twenty times the expected run
    initial begin
        #100000;
        failures++;
        conclude();
    end

    // Main sequence
    initial begin
        dbcm_pkg::dbcm_bus_t b;
        repeat (20) @(posedge SYS_CLK);
        RESET <= 1'h0;
        chk(10'h118, '0);
        chk(10'h11C, '0);
        chk(10'h120, '0);
        chk(10'h124, '0);
        chk(10'h1F0, '0);
        cfg(32'h11223344, 32'hFFFFFFFF, 8'hFF, 24'hABCDEF);
        chk(10'h120, 32'h2D);
        av(1'h1, 10'h118, 4'h8, 32'h5A000000);
        av(1'h1, 10'h11C, 4'h1, 32'h0F);
        dv = 32'h1122335A;
        dm = 32'h0FFFFFFF;
        chk(10'h118, sw(dv));
        chk(10'h11C, sw(dm));
        chk(10'h124, 32'hABCDEF);
        // Armed: writes acknowledged but dropped
        av(1'h1, 10'h100, 4'h1, 32'h1);
        arm = 1'h1;
        // Arm lands at the answer edge; look one edge later
        @(posedge SYS_CLK);
        `CHK(ARMED, 1'h1)
        cfg('0, '0, '0, '0);
        chk(10'h118, sw(dv));
        chk(10'h120, 32'h2D);
        chk(10'h124, 32'hABCDEF);
        @(posedge SYS_CLK);
        SEQ_FINAL <= 1'h1;
        @(posedge SYS_CLK);
        SEQ_FINAL <= 1'h0;
        #1;
        `CHK(ARMED, 1'h0)
        arm = 1'h0;
        // Every control combination against each kind of cycle
        for (int k = 0; k < 16; k++) begin
            cfg(xs(), xs(), {2'h0, k[3], 1'h0, k[2], k[1], 1'h0, k[0]},
                24'(xs()));
            for (int j = 0; j < 4; j++) begin
                b = 82'({xs(), xs(), xs()});
                b.valid = j != 2;
                b.read = j[0];
                b.opc_exec = j >= 2;
                b.addr = ba ^ 24'(j == 3);
                b.opc_addr = b.addr;
                cyc(b, 8'(xs()) & 8'h2D);
            end
        end
        // Random traffic, hits forced half the time; then range mode
        for (int i = 0; i < 340; i++) begin
            if (i % 30 == 0) cfg(xs(), xs(), 8'(xs()), 24'(xs()));
            if (i == 300) av(1'h1, 10'h100, 4'h1, 32'h2);
            rng = i >= 300;
            b = 82'({xs(), xs(), xs()});
            rd = xs();
            if (rd[0]) b.addr = ba;
            if (rd[1]) b.opc_addr = ba;
            if (rd[2]) b.data = dv ^ (xs() & ~dm);
            cyc(b, 8'(xs()) & 8'h2D);
        end
        conclude();
    end
endmodule
